// *** verilog/ramp_sequencer.sv ***
// Operation
// - Stop ramps, and start ramps once outputs enable, run with the loop closed on the moving reference.
// - Ramp, normal and light-load modes each select their own gain bank.
// - Turn-on waits the start delay, then ramps toward target at derived rate.
// - Outputs enable once ramp reaches output voltage and duty exceeds minimum.
// - Idle keeps outputs off and makes the reference follow feedback.
// - Pre-bias duty is computed as measured output over input voltage.
// - Below minimum pulse, outputs stay off until the ramp raises duty.
// - Reference steps at 10 kHz, sized from rise or fall setting.
// - Without saturation, regulation comes exactly delay plus rise after turn-on acceptance.
// - Normal ramp slews at a precomputed rate from target and rise time.
// - Sampler saturation steps reference to cut error, then ramp resumes.
`timescale 1ns/100ps
module ramp_sequencer
    import ramp_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [15:0] FB_VOLT,
    input wire logic [15:0] VIN_VOLT,
    input wire logic SAT_POS,
    input wire logic SAT_NEG,
    input wire logic LIGHT_LOAD,
    output logic [15:0] VREF,
    output logic PWM_EN,
    output logic [1:0] GAIN_BANK,
    output logic RAMP_MODE,
    output logic [11:0] DUTY_FF
);

    // ********************************************************************
    // Input synchronisers
    // ********************************************************************
    logic [35:0] sync1_q, sync2_q;
    logic [15:0] fb_s, vin_s;
    logic sat_pos_s, sat_neg_s, light_s;

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            sync1_q <= 36'h0_0000_0000;
            sync2_q <= 36'h0_0000_0000;
        end
        else
        begin
            sync1_q <= {FB_VOLT, VIN_VOLT, SAT_POS, SAT_NEG, LIGHT_LOAD,
                        1'b0};
            sync2_q <= sync1_q;
        end
    end

    assign {fb_s, vin_s, sat_pos_s, sat_neg_s, light_s} = sync2_q[35:1];

    // ********************************************************************
    // AHB-Lite register slave
    // ********************************************************************
    function automatic logic [3:0] reg_index(input logic [31:0] addr);
        logic [3:0] idx;
        idx = IDX_NONE;
        if (addr[31:12] == 20'h00000)
        begin
            case (addr[11:0])
                CTRL_OFS: idx = IDX_CTRL;
                BANKS_OFS: idx = IDX_BANKS;
                DELAY_OFS: idx = IDX_DELAY;
                RISE_OFS: idx = IDX_RISE;
                FALL_OFS: idx = IDX_FALL;
                TARGET_OFS: idx = IDX_TARGET;
                MINP_OFS: idx = IDX_MINP;
                STATUS_OFS: idx = IDX_STATUS;
                DUTY_OFS: idx = IDX_DUTY;
                default: idx = IDX_NONE;
            endcase
        end
        return idx;
    endfunction : reg_index

    cfg_s cfg_q, cfg_d;
    ahb_phase_s ahb_q, ahb_d;
    logic [31:0] rdata_d;
    seq_state_e state_q, state_d;
    logic [31:0] ramp_q, ramp_d;
    logic [11:0] duty_d;

    always_comb
    begin
        ahb_d.valid = HSEL && HTRANS[1] && HREADY;
        ahb_d.write = HWRITE;
        ahb_d.idx = reg_index(HADDR);
        cfg_d = cfg_q;
        if (ahb_q.valid && ahb_q.write)
        begin
            case (ahb_q.idx)
                IDX_CTRL: cfg_d.run = HWDATA[0];
                IDX_BANKS: cfg_d.banks = HWDATA[5:0];
                IDX_DELAY: cfg_d.delay = HWDATA[15:0];
                IDX_RISE: cfg_d.rise = HWDATA[15:0];
                IDX_FALL: cfg_d.fall = HWDATA[15:0];
                IDX_TARGET: cfg_d.target = HWDATA[15:0];
                IDX_MINP: cfg_d.min_pulse = HWDATA[11:0];
                default: cfg_d = cfg_q;
            endcase
        end
        // Read mux sees pending write so back-to-back read is current
        rdata_d = HRDATA;
        if (ahb_d.valid && !ahb_d.write)
        begin
            case (ahb_d.idx)
                IDX_CTRL: rdata_d = {31'h0000_0000, cfg_d.run};
                IDX_BANKS: rdata_d = {26'h000_0000, cfg_d.banks};
                IDX_DELAY: rdata_d = {16'h0000, cfg_d.delay};
                IDX_RISE: rdata_d = {16'h0000, cfg_d.rise};
                IDX_FALL: rdata_d = {16'h0000, cfg_d.fall};
                IDX_TARGET: rdata_d = {16'h0000, cfg_d.target};
                IDX_MINP: rdata_d = {20'h0_0000, cfg_d.min_pulse};
                IDX_STATUS: rdata_d = {7'h00, PWM_EN, 3'h0, state_q, VREF};
                IDX_DUTY: rdata_d = {ramp_q[31:16], 4'h0, DUTY_FF};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            ahb_q <= '0;
            cfg_q <= '{run: 1'b0, banks: BANKS_RST, delay: DELAY_RST,
                       rise: RISE_RST, fall: FALL_RST, target: TARGET_RST,
                       min_pulse: MINP_RST};
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
        else
        begin
            ahb_q <= ahb_d;
            cfg_q <= cfg_d;
            HRDATA <= rdata_d;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // ********************************************************************
    // Update tick and dividers
    // ********************************************************************
    logic tick, tick_clr;
    logic step_start, pre_start, step_done, pre_done;
    logic [31:0] step_num, step_q, pre_q;
    logic [15:0] step_den;

    ramp_tick #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_tick (
        .clk(CLK),
        .resetn(RESETN),
        .clear(tick_clr),
        .tick(tick)
    );

    ramp_divider u_step_div (
        .clk(CLK),
        .resetn(RESETN),
        .start(step_start),
        .num(step_num),
        .den(step_den),
        .done(step_done),
        .quot(step_q)
    );

    // Feedback over input voltage, scaled to full duty
    ramp_divider u_prebias_div (
        .clk(CLK),
        .resetn(RESETN),
        .start(pre_start),
        .num({4'h0, fb_s, 12'h000}),
        .den(vin_s),
        .done(pre_done),
        .quot(pre_q)
    );

    // ********************************************************************
    // Ramp sequencer
    // ********************************************************************
    logic [15:0] cnt_q, cnt_d;
    logic pwm_d, sat_any, duty_ok, ramp_ok;
    logic [15:0] vref_d;
    logic [1:0] bank_d;
    logic [27:0] min_prod;

    assign sat_any = sat_pos_s || sat_neg_s;
    assign min_prod = 28'(cfg_q.min_pulse) * 28'(vin_s);
    assign duty_ok = {ramp_q[31:16], 12'h000} > min_prod;
    assign ramp_ok = ramp_q[31:16] >= fb_s;

    always_comb
    begin
        state_d = state_q;
        ramp_d = ramp_q;
        cnt_d = cnt_q;
        pwm_d = PWM_EN;
        tick_clr = 1'b0;
        step_start = 1'b0;
        pre_start = 1'b0;
        step_num = {cfg_q.target, 16'h0000};
        step_den = cfg_q.rise;
        case (state_q)
            ST_IDLE:
            begin
                pwm_d = 1'b0;
                ramp_d = 32'h0000_0000;
                if (cfg_q.run)
                begin
                    tick_clr = 1'b1;
                    step_start = 1'b1;
                    pre_start = 1'b1;
                    cnt_d = 16'h0000;
                    state_d = (cfg_q.delay == 16'h0000) ? ST_RISE : ST_DELAY;
                end
            end
            ST_DELAY:
            begin
                if (!cfg_q.run)
                begin
                    state_d = ST_IDLE;
                end
                else if (tick)
                begin
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_d >= cfg_q.delay)
                    begin
                        cnt_d = 16'h0000;
                        state_d = ST_RISE;
                    end
                end
            end
            ST_RISE, ST_FALL:
            begin
                if (state_q == ST_RISE && !cfg_q.run)
                begin
                    step_num = ramp_q;
                    step_den = cfg_q.fall;
                    step_start = PWM_EN;
                    cnt_d = 16'h0000;
                    state_d = PWM_EN ? ST_FALL : ST_IDLE;
                end
                else if (tick && sat_any && PWM_EN)
                begin
                    // Override the ramp toward smaller error, hold the count
                    if (sat_pos_s)
                        ramp_d = (ramp_q >= SAT_STEP) ? ramp_q - SAT_STEP
                                                       : 32'h0000_0000;
                    else
                        ramp_d = ramp_q + SAT_STEP;
                end
                else if (state_q == ST_RISE && tick)
                begin
                    cnt_d = cnt_q + 16'h0001;
                    ramp_d = ramp_q + step_q;
                    if (cnt_d >= cfg_q.rise)
                    begin
                        ramp_d = {cfg_q.target, 16'h0000};
                        cnt_d = 16'h0000;
                        state_d = ST_REG;
                    end
                end
                else if (state_q == ST_FALL && tick)
                begin
                    cnt_d = cnt_q + 16'h0001;
                    ramp_d = (ramp_q >= step_q) ? ramp_q - step_q
                                                : 32'h0000_0000;
                    if (cnt_d >= cfg_q.fall || ramp_d == 32'h0000_0000)
                    begin
                        ramp_d = 32'h0000_0000;
                        pwm_d = 1'b0;
                        state_d = ST_IDLE;
                    end
                end
                if (state_q == ST_RISE && state_d == ST_RISE && !PWM_EN &&
                    ramp_ok && duty_ok)
                    pwm_d = 1'b1;
            end
            ST_REG:
            begin
                if (cfg_q.run && !PWM_EN && ramp_ok && duty_ok)
                    pwm_d = 1'b1;
                if (!cfg_q.run)
                begin
                    step_num = ramp_q;
                    step_den = cfg_q.fall;
                    step_start = 1'b1;
                    cnt_d = 16'h0000;
                    state_d = PWM_EN ? ST_FALL : ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
                pwm_d = 1'b0;
            end
        endcase
        // Closed loop follows the ramp; otherwise track the feedback
        vref_d = pwm_d ? ramp_d[31:16] : fb_s;
        if (state_d != ST_REG)
            bank_d = cfg_q.banks[1:0];
        else if (light_s)
            bank_d = cfg_q.banks[5:4];
        else
            bank_d = cfg_q.banks[3:2];
        duty_d = DUTY_FF;
        if (pre_done)
            duty_d = (pre_q[31:12] != 20'h0_0000) ? 12'hFFF : pre_q[11:0];
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            state_q <= ST_IDLE;
            ramp_q <= 32'h0000_0000;
            cnt_q <= 16'h0000;
            PWM_EN <= 1'b0;
            VREF <= 16'h0000;
            GAIN_BANK <= 2'h0;
            RAMP_MODE <= 1'b1;
            DUTY_FF <= 12'h000;
        end
        else
        begin
            state_q <= state_d;
            ramp_q <= ramp_d;
            cnt_q <= cnt_d;
            PWM_EN <= pwm_d;
            VREF <= vref_d;
            GAIN_BANK <= bank_d;
            RAMP_MODE <= (state_d != ST_REG);
            DUTY_FF <= duty_d;
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    logic [16:0] tk_q;
    logic sat_seen_q;

    always_ff @(posedge CLK)
    begin
        if (!RESETN || state_q == ST_IDLE)
        begin
            tk_q <= 17'h00000;
            sat_seen_q <= 1'b0;
        end
        else
        begin
            tk_q <= tk_q + {16'h0000, tick};
            sat_seen_q <= sat_seen_q || (sat_any && PWM_EN);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    a_idle_off: assert property (
        state_q == ST_IDLE |-> !PWM_EN)
        else $error("outputs enabled while idle");
    a_idle_track: assert property (
        (state_q == ST_IDLE && $stable(fb_s)) [*3] |-> VREF == fb_s)
        else $error("idle reference not tracking feedback");
    a_pwm_gate: assert property (
        $rose(PWM_EN) |-> $past(ramp_ok) && $past(duty_ok))
        else $error("outputs enabled before ramp and pulse allow");
    a_loop_follow: assert property (
        PWM_EN |-> VREF == ramp_q[31:16])
        else $error("reference not following ramp when closed");
    a_reg_time: assert property (
        (state_q == ST_RISE && state_d == ST_REG && tick && !sat_seen_q)
        |-> tk_q + 17'h00001 == {1'b0, cfg_q.delay} + {1'b0, cfg_q.rise})
        else $error("regulation not reached at delay plus rise");
    a_reg_target: assert property (
        $rose(state_q == ST_REG) && $past(state_q == ST_RISE)
        |-> ramp_q == {$past(cfg_q.target), 16'h0000})
        else $error("regulation entered off target");
    a_ramp_step: assert property (
        state_q == ST_RISE && state_d == ST_RISE && tick && cfg_q.run &&
        !(sat_any && PWM_EN) |=> ramp_q == $past(ramp_q) + $past(step_q))
        else $error("ramp step not applied on tick");
    a_sat_down: assert property (
        state_q == ST_RISE && cfg_q.run && tick && sat_pos_s && PWM_EN &&
        ramp_q >= SAT_STEP |=> ramp_q == $past(ramp_q) - SAT_STEP)
        else $error("saturation did not step reference down");
    a_bank_sel: assert property (
        state_q == ST_REG && state_d == ST_REG && !light_s
        |=> GAIN_BANK == $past(cfg_q.banks[3:2]))
        else $error("wrong gain bank in regulation");
    a_stop_idle: assert property (
        state_q == ST_FALL && state_d == ST_IDLE |=> !PWM_EN && VREF == fb_s
        ##1 state_q == ST_IDLE)
        else $error("stop ramp did not return to idle");
    a_prebias_calc: assert property (
        pre_start |-> ##[33:34] pre_done)
        else $error("pre-bias duty not computed in time");

endmodule : ramp_sequencer

// *** inc/ramp_pkg.sv ***
package ramp_pkg;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int UPDATE_HZ = 10_000;
    localparam int TICK_CYCLES = CLK_HZ / UPDATE_HZ;
    localparam int FRAC_BITS = 16;
    localparam int DUTY_BITS = 12;
    localparam logic [5:0] DIV_STEPS = 6'h20;
    localparam logic [31:0] SAT_STEP = 32'h0001_0000;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] BANKS_OFS = 12'h004;
    localparam logic [11:0] DELAY_OFS = 12'h008;
    localparam logic [11:0] RISE_OFS = 12'h00C;
    localparam logic [11:0] FALL_OFS = 12'h010;
    localparam logic [11:0] TARGET_OFS = 12'h014;
    localparam logic [11:0] MINP_OFS = 12'h018;
    localparam logic [11:0] STATUS_OFS = 12'h01C;
    localparam logic [11:0] DUTY_OFS = 12'h020;

    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_BANKS = 4'h1;
    localparam logic [3:0] IDX_DELAY = 4'h2;
    localparam logic [3:0] IDX_RISE = 4'h3;
    localparam logic [3:0] IDX_FALL = 4'h4;
    localparam logic [3:0] IDX_TARGET = 4'h5;
    localparam logic [3:0] IDX_MINP = 4'h6;
    localparam logic [3:0] IDX_STATUS = 4'h7;
    localparam logic [3:0] IDX_DUTY = 4'h8;
    localparam logic [3:0] IDX_NONE = 4'hF;

    localparam logic [5:0] BANKS_RST = 6'h24;
    localparam logic [15:0] DELAY_RST = 16'h000A;
    localparam logic [15:0] RISE_RST = 16'h0032;
    localparam logic [15:0] FALL_RST = 16'h0032;
    localparam logic [15:0] TARGET_RST = 16'h0000;
    localparam logic [11:0] MINP_RST = 12'h000;

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_DELAY = 5'b00010,
        ST_RISE = 5'b00100,
        ST_REG = 5'b01000,
        ST_FALL = 5'b10000
    } seq_state_e;

    typedef struct packed {
        logic run;
        logic [5:0] banks;
        logic [15:0] delay;
        logic [15:0] rise;
        logic [15:0] fall;
        logic [15:0] target;
        logic [11:0] min_pulse;
    } cfg_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] idx;
    } ahb_phase_s;

endpackage : ramp_pkg

// *** verilog/ramp_tick.sv ***
`timescale 1ns/100ps
module ramp_tick
    import ramp_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic clear,
    output logic tick
);

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic tick_d;

    always_comb
    begin
        tick_d = 1'b0;
        cnt_d = cnt_q + 32'h0000_0001;
        if (clear)
        begin
            cnt_d = 32'h0000_0000;
        end
        else if (cnt_q == 32'(TICK_CYCLES_P - 1))
        begin
            cnt_d = 32'h0000_0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cnt_q <= 32'h0000_0000;
            tick <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end

endmodule : ramp_tick

// *** verilog/ramp_divider.sv ***
`timescale 1ns/100ps
module ramp_divider
    import ramp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [31:0] num,
    input wire logic [15:0] den,
    output logic done,
    output logic [31:0] quot
);

    logic [31:0] num_q, num_d, quot_d;
    logic [16:0] rem_q, rem_d, trial;
    logic [15:0] den_q, den_d;
    logic [5:0] cnt_q, cnt_d;
    logic busy_q, busy_d, done_d;

    // Restoring division, one quotient bit per cycle
    always_comb
    begin
        num_d = num_q;
        rem_d = rem_q;
        den_d = den_q;
        quot_d = quot;
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        trial = {rem_q[15:0], num_q[31]};
        if (start)
        begin
            num_d = num;
            rem_d = 17'h00000;
            den_d = (den == 16'h0000) ? 16'h0001 : den;
            quot_d = 32'h0000_0000;
            cnt_d = DIV_STEPS;
            busy_d = 1'b1;
        end
        else if (busy_q)
        begin
            num_d = {num_q[30:0], 1'b0};
            if (trial >= {1'b0, den_q})
            begin
                rem_d = trial - {1'b0, den_q};
                quot_d = {quot[30:0], 1'b1};
            end
            else
            begin
                rem_d = trial;
                quot_d = {quot[30:0], 1'b0};
            end
            cnt_d = cnt_q - 6'h01;
            if (cnt_q == 6'h01)
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            num_q <= 32'h0000_0000;
            rem_q <= 17'h00000;
            den_q <= 16'h0001;
            quot <= 32'h0000_0000;
            cnt_q <= 6'h00;
            busy_q <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            num_q <= num_d;
            rem_q <= rem_d;
            den_q <= den_d;
            quot <= quot_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done <= done_d;
        end
    end

endmodule : ramp_divider

// *** verif/power_stage_model.sv ***
`timescale 1ns/100ps
module power_stage_model
#(
    parameter logic [15:0] VIN_P = 16'h8000,
    parameter logic [15:0] SLEW_P = 16'hFFFF
)
(
    input wire logic clk,
    input wire logic pwm_en,
    input wire logic [15:0] vref,
    input wire logic [15:0] prebias,
    output logic [15:0] fb = 16'h0000,
    output logic [15:0] vin
);
    // ***********************************************
    // Output follows the reference while driven
    // ***********************************************
    logic [15:0] goal;
    assign goal = pwm_en ? vref : prebias;
    assign vin = VIN_P;
    // Undriven output relaxes back to its pre-bias level
    always @(posedge clk)
    begin
        if (goal > fb && goal - fb > SLEW_P)
            fb <= fb + SLEW_P;
        else if (goal < fb && fb - goal > SLEW_P)
            fb <= fb - SLEW_P;
        else
            fb <= goal;
    end
endmodule : power_stage_model

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    import ramp_pkg::*;
    localparam int TK = 64;
    typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d;} row_s;
    logic clk, resetn, hsel, hwrite, sat_pos, sat_neg, light_load;
    logic hreadyout, hresp, pwm_en, ramp_mode;
    logic [1:0] htrans, gain_bank;
    logic [11:0] duty_ff;
    logic [15:0] fb_volt, vin_volt, vref;
    logic [31:0] haddr, hwdata, hrdata, q;
    int n_fail, comparisons, t_pwm, t_reg;
    row_s rows [18] = '{{1'h0, BANKS_OFS, 32'h24}, {1'h0, DELAY_OFS, 32'hA},
        {1'h0, RISE_OFS, 32'h32}, {1'h0, FALL_OFS, 32'h32},
        {1'h0, TARGET_OFS, 32'h0}, {1'h0, MINP_OFS, 32'h0},
        {1'h0, CTRL_OFS, 32'h0}, {1'h0, 12'h040, 32'h0},
        {1'h1, 12'h040, 32'hFFFFFFFF}, {1'h0, 12'h040, 32'h0},
        {1'h1, DELAY_OFS, 32'h2}, {1'h0, DELAY_OFS, 32'h2},
        {1'h1, RISE_OFS, 32'h4}, {1'h1, FALL_OFS, 32'h3},
        {1'h1, TARGET_OFS, 32'h4000}, {1'h0, TARGET_OFS, 32'h4000},
        {1'h1, MINP_OFS, 32'h300}, {1'h0, MINP_OFS, 32'h300}};

    ramp_sequencer #(.TICK_CYCLES_P(TK)) dut_u (.CLK(clk), .RESETN(resetn),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .FB_VOLT(fb_volt),
        .VIN_VOLT(vin_volt), .SAT_POS(sat_pos), .SAT_NEG(sat_neg),
        .LIGHT_LOAD(light_load), .VREF(vref), .PWM_EN(pwm_en),
        .GAIN_BANK(gain_bank), .RAMP_MODE(ramp_mode), .DUTY_FF(duty_ff));
    power_stage_model ps_u (.clk(clk), .pwm_en(pwm_en), .vref(vref),
        .prebias(16'h1000), .fb(fb_volt), .vin(vin_volt));

    // ***********************************************
    // Bus cycles and comparisons
    // ***********************************************
    task automatic tally_and_finish();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic stuck();
        n_fail++;
        tally_and_finish();
    endtask : stuck
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_in(input int t, input int lo, input int hi);
        comparisons++;
        if (t < lo || t > hi)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, t, lo, hi);
        end
    endtask : chk_in
    task automatic wrdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) stuck();
    endtask : wrdy
    task automatic bus(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0, a};
        wrdy();
        htrans <= 2'h0;
        hwdata <= d;
        wrdy();
        rd = hrdata;
    endtask : bus
    // Turn on and time the enable and the end of the ramp
    task automatic start(input int sat_at);
        int t;
        t_pwm = -1;
        t_reg = -1;
        bus(1'h1, CTRL_OFS, 32'h1, q);
        for (t = 1; t < 2000 && t_reg < 0; t++)
        begin
            @(posedge clk);
            if (pwm_en === 1'b1 && t_pwm < 0) t_pwm = t;
            if (ramp_mode === 1'b0) t_reg = t;
            if (t == 100) chk({20'h0, duty_ff}, 32'h200);
            if (t == 100) chk({30'h0, gain_bank}, 32'h0);
            sat_pos <= (t >= sat_at && t < sat_at + TK);
            sat_neg <= (t >= sat_at + TK && t < sat_at + 2 * TK);
        end
        if (t_reg < 0) stuck();
        @(posedge clk);
        chk({16'h0, vref}, 32'h4000);
    endtask : start
    task automatic stop_run();
        int t;
        bus(1'h1, CTRL_OFS, 32'h0, q);
        for (t = 1; t < 1000 && pwm_en !== 1'b0; t++) @(posedge clk);
        chk_in(t, 2 * TK, 3 * TK + 4);
        repeat (10) @(posedge clk);
        chk({31'h0, ramp_mode}, 32'h1);
        chk({16'h0, vref}, 32'h1000);
    endtask : stop_run

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ***********************************************
    // Main sequence
    // ***********************************************
    initial
    begin
        {resetn, hsel, hwrite, sat_pos, sat_neg, light_load} = 6'h0;
        {htrans, haddr, hwdata} = '0;
        n_fail = 0;
        comparisons = 0;
        repeat (8) @(posedge clk);
        chk({31'h0, pwm_en}, 32'h0);
        resetn <= 1'b1;
        foreach (rows[i])
        begin
            bus(rows[i].wr, rows[i].a, rows[i].d, q);
            if (!rows[i].wr) chk(q, rows[i].d);
        end
        chk({31'h0, hresp}, 32'h0);
        chk({16'h0, vref}, 32'h1000);
        start(5000);
        chk_in(t_pwm, 4 * TK, 4 * TK + 4);
        chk_in(t_reg, 6 * TK, 6 * TK + 4);
        chk({30'h0, gain_bank}, 32'h1);
        bus(1'h0, STATUS_OFS, 32'h0, q);
        chk(q, 32'h0108_4000);
        bus(1'h0, DUTY_OFS, 32'h0, q);
        chk(q, 32'h4000_0200);
        light_load <= 1'b1;
        repeat (6) @(posedge clk);
        chk({30'h0, gain_bank}, 32'h2);
        light_load <= 1'b0;
        stop_run();
        bus(1'h1, MINP_OFS, 32'h0, q);
        start(4 * TK + 10);
        chk_in(t_pwm, 3 * TK, 3 * TK + 4);
        chk_in(t_reg, 8 * TK - 2, 8 * TK + 6);
        stop_run();
        tally_and_finish();
    end
endmodule : tb_top
